// ===== shared/ecc_pkg.sv
// Package for the excitation current control register block.
// Assumes an 8-bit special-function bus from the core, one clock domain.
`default_nettype none
package ecc_pkg;
   localparam logic [7:0] ECC_REG_ADDR = 8'hd5;
   localparam logic [7:0] ECC_RESET_VAL = 8'h00;
   localparam logic [7:0] ECC_WRITE_MASK = 8'h7f;
   localparam int ECC_BIT_RESERVED = 7;
   localparam int ECC_BIT_BURNOUT = 6;
   localparam int ECC_BIT_AUX_CORR = 5;
   localparam int ECC_BIT_PRI_CORR = 4;
   localparam int ECC_BIT_SRC2_PIN = 3;
   localparam int ECC_BIT_SRC1_PIN = 2;
   localparam int ECC_BIT_SRC2_EN = 1;
   localparam int ECC_BIT_SRC1_EN = 0;

   // Analog control outputs toward the current source cells
   typedef struct packed {
      logic burnout_source_enable;
      logic aux_current_correction;
      logic primary_current_correction;
      logic [1:0] first_excitation_pin;
      logic [1:0] second_excitation_pin;
   } ecc_ctrl_t;

   typedef struct packed {
      logic [7:0] ctrl_reg;
   } ecc_state_t;
endpackage : ecc_pkg
`default_nettype wire

// ===== src/ecc_regs.sv
// Excitation current control register and its source routing decode.
// Assumes the core's SFR bus is synchronous to core_clk_in; byte access only.
//
// Notes on behaviour
// - The register lives at SFR address d5 and resets to all zeros.
// - Only whole-byte reads and writes reach it; bit access is not decoded.
// - Bit 7 is reserved, stores nothing and reads zero.
// - Bit 6 drives both burnout source enables together.
// - Bit 5 enables current correction scaling of the auxiliary converter.
// - Bit 4 enables current correction scaling of the primary converter.
// - Bit 3 high sends source two to the first pin, low to the second pin.
// - Bit 2 high sends source one to the second pin, low to the first pin.
// - Bit 1 turns source two on or off.
// - Bit 0 turns source one on or off.
// - Both sources may land on the same pin at once for a doubled current.
`timescale 1ns/100ps
`default_nettype none
module ecc_regs
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   output logic [7:0] sfr_rdata_out,
   output logic sfr_hit_out,
   output ecc_pkg::ecc_ctrl_t ctrl_out
);

   ////////////////////////////////////////////////////////////////////////
   ecc_pkg::ecc_state_t state_reg;
   ecc_pkg::ecc_state_t state_next;

   // Address decode, shared by read and write paths
   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == ecc_pkg::ECC_REG_ADDR);
   endfunction : addr_hit

   // Next state: whole-byte write, reserved bit masked off
   always_comb
   begin
      state_next = state_reg;
      if (sfr_wr_in && addr_hit(sfr_addr_in))
      begin
         state_next.ctrl_reg = sfr_wdata_in & ecc_pkg::ECC_WRITE_MASK;
      end
   end

   // Register; clock enable freezes it
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         state_reg <= '{ctrl_reg: ecc_pkg::ECC_RESET_VAL};
      end
      else if (clk_en_in)
      begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; hit is combinational so the core can mux its bus
   assign sfr_hit_out = addr_hit(sfr_addr_in) && (sfr_rd_in || sfr_wr_in);
   assign sfr_rdata_out = (sfr_rd_in && addr_hit(sfr_addr_in)) ?
                          state_reg.ctrl_reg : 8'h00;

   // Routing: each pin carries a two-bit source mask, so both may share a pin
   logic src1_on;
   logic src2_on;
   logic src1_sel;
   logic src2_sel;
   assign src1_on = state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC1_EN];
   assign src2_on = state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC2_EN];
   assign src1_sel = state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC1_PIN];
   assign src2_sel = state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC2_PIN];
   always_comb
   begin
      ctrl_out.burnout_source_enable = state_reg.ctrl_reg[ecc_pkg::ECC_BIT_BURNOUT];
      ctrl_out.aux_current_correction = state_reg.ctrl_reg[ecc_pkg::ECC_BIT_AUX_CORR];
      ctrl_out.primary_current_correction =
         state_reg.ctrl_reg[ecc_pkg::ECC_BIT_PRI_CORR];
      ctrl_out.first_excitation_pin = {src2_on && src2_sel, src1_on && !src1_sel};
      ctrl_out.second_excitation_pin = {src2_on && !src2_sel, src1_on && src1_sel};
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks; one clock domain, so default clocking and reset cover all but the two reset checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   // Strobes decoded from the package address, not from addr_hit, so a bad
   // decode function cannot hide its own fault
   logic chk_wr_taken;
   logic chk_wr_here;
   logic chk_rd_here;
   assign chk_wr_here = sfr_wr_in && (sfr_addr_in == ecc_pkg::ECC_REG_ADDR);
   assign chk_wr_taken = chk_wr_here && clk_en_in;
   assign chk_rd_here = sfr_rd_in && (sfr_addr_in == ecc_pkg::ECC_REG_ADDR);

   // Reset clears the byte and every control; reset must not mask its own check
   a_reset_clear: assert property (@(posedge core_clk_in) disable iff (1'b0)
      rst_in |=> state_reg.ctrl_reg == ecc_pkg::ECC_RESET_VAL)
      else $error("reset not zero");
   a_reset_outputs: assert property (@(posedge core_clk_in) disable iff (1'b0)
      rst_in |=> ctrl_out == '0 && sfr_rdata_out == 8'h00)
      else $error("controls not off after reset");

   // Whole-byte write lands on one edge, reserved bit dropped
   a_write_updates: assert property (
      chk_wr_taken |=> state_reg.ctrl_reg ==
      ($past(sfr_wdata_in) & ecc_pkg::ECC_WRITE_MASK))
      else $error("write not stored");

   // Nothing but a write to this address may move the byte
   a_other_addr_hold: assert property (
      !chk_wr_here |=> $stable(state_reg.ctrl_reg))
      else $error("register changed without write");

   // A low clock enable freezes the state, writes included
   a_freeze_hold: assert property (
      !clk_en_in |=> $stable(state_reg))
      else $error("state moved while frozen");

   // Reserved bit neither stores nor reads back
   a_reserved_zero: assert property (
      sfr_rd_in |-> !sfr_rdata_out[ecc_pkg::ECC_BIT_RESERVED])
      else $error("reserved bit read one");
   a_reserved_store: assert property (
      !state_reg.ctrl_reg[ecc_pkg::ECC_BIT_RESERVED])
      else $error("reserved bit stored");

   // Burnout pair follows its bit, and a write reaches it one edge later
   a_burnout_follow: assert property (
      ctrl_out.burnout_source_enable == state_reg.ctrl_reg[ecc_pkg::ECC_BIT_BURNOUT])
      else $error("burnout wrong");
   a_burnout_write: assert property (
      chk_wr_taken |=> ctrl_out.burnout_source_enable ==
      $past(sfr_wdata_in[ecc_pkg::ECC_BIT_BURNOUT]))
      else $error("burnout write lost");

   // Correction enables, one per converter
   a_corr_follow: assert property (
      ctrl_out.aux_current_correction == state_reg.ctrl_reg[ecc_pkg::ECC_BIT_AUX_CORR] &&
      ctrl_out.primary_current_correction ==
      state_reg.ctrl_reg[ecc_pkg::ECC_BIT_PRI_CORR])
      else $error("correction wrong");
   a_aux_corr_write: assert property (
      chk_wr_taken |=> ctrl_out.aux_current_correction ==
      $past(sfr_wdata_in[ecc_pkg::ECC_BIT_AUX_CORR]))
      else $error("aux correction write lost");
   a_pri_corr_write: assert property (
      chk_wr_taken |=> ctrl_out.primary_current_correction ==
      $past(sfr_wdata_in[ecc_pkg::ECC_BIT_PRI_CORR]))
      else $error("primary correction write lost");

   // Source two: bit set sends it to the first pin, clear to the second
   a_src_two_route: assert property (
      state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC2_EN] |->
      (ctrl_out.first_excitation_pin[1] == state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC2_PIN]) &&
      (ctrl_out.second_excitation_pin[1] != state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC2_PIN]))
      else $error("source two misrouted");

   // Source one: bit set sends it to the second pin, clear to the first
   a_src_one_route: assert property (
      state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC1_EN] |->
      (ctrl_out.second_excitation_pin[0] == state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC1_PIN]) &&
      (ctrl_out.first_excitation_pin[0] != state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC1_PIN]))
      else $error("source one misrouted");

   // A disabled source shows on neither pin, whatever its pin select says
   a_src_two_off: assert property (
      !state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC2_EN] |->
      !ctrl_out.first_excitation_pin[1] && !ctrl_out.second_excitation_pin[1])
      else $error("source two on while disabled");
   a_src_one_off: assert property (
      !state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC1_EN] |->
      !ctrl_out.first_excitation_pin[0] && !ctrl_out.second_excitation_pin[0])
      else $error("source one on while disabled");
   a_sources_off: assert property (
      !state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC2_EN] &&
      !state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC1_EN] |->
      ctrl_out.first_excitation_pin == 2'h0 && ctrl_out.second_excitation_pin == 2'h0)
      else $error("source on while disabled");

   // An enabled source sits on exactly one pin
   a_src_two_once: assert property (
      state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC2_EN] |->
      ctrl_out.first_excitation_pin[1] != ctrl_out.second_excitation_pin[1])
      else $error("source two not on one pin");
   a_src_one_once: assert property (
      state_reg.ctrl_reg[ecc_pkg::ECC_BIT_SRC1_EN] |->
      ctrl_out.first_excitation_pin[0] != ctrl_out.second_excitation_pin[0])
      else $error("source one not on one pin");

   // Both sources may share either pin; the decode must not block it
   a_shared_pin: assert property (
      state_reg.ctrl_reg[3:0] == 4'hb |-> ctrl_out.first_excitation_pin == 2'h3)
      else $error("shared pin blocked");
   a_shared_second: assert property (
      state_reg.ctrl_reg[3:0] == 4'h7 |-> ctrl_out.second_excitation_pin == 2'h3)
      else $error("second shared pin blocked");

   // Read side: stored byte while selected, zero otherwise, hit on either strobe
   a_read_data: assert property (
      chk_rd_here |-> sfr_rdata_out == state_reg.ctrl_reg)
      else $error("read mismatch");
   a_read_idle: assert property (
      !chk_rd_here |-> sfr_rdata_out == 8'h00)
      else $error("read data not idle");
   a_hit_decode: assert property (
      sfr_hit_out == ((sfr_rd_in || sfr_wr_in) &&
      sfr_addr_in == ecc_pkg::ECC_REG_ADDR))
      else $error("hit decode wrong");

   // Main scenarios: taken and frozen writes, shared pins, burnout on
   c_write: cover property (chk_wr_taken);
   c_frozen_write: cover property (chk_wr_here && !clk_en_in);
   c_shared_first: cover property (ctrl_out.first_excitation_pin == 2'h3);
   c_shared_second: cover property (ctrl_out.second_excitation_pin == 2'h3);
   c_burnout: cover property (ctrl_out.burnout_source_enable);

endmodule : ecc_regs
`default_nettype wire

// ===== dv/ecc_core_model.sv
// Core-side SFR master model: whole-byte reads and writes.
// Assumes the bench calls its tasks; drives just after the falling edge.
`timescale 1ns/100ps
`default_nettype none
module ecc_core_model
(
   input wire logic core_clk_in,
   input wire logic [7:0] rdata_in,
   input wire logic hit_in,
   output var logic [7:0] addr_out,
   output var logic [7:0] wdata_out,
   output var logic wr_out,
   output var logic rd_out
);
   initial {addr_out, wdata_out, wr_out, rd_out} = 18'h00000;
   ////////////////////////////////////////////////////////////////////////////
   // One-cycle write pulse; bus inverted after release, not left holding
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge core_clk_in);
      wr_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask : wr_byte
   // Read strobe held until the sampling edge; data and hit taken there
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(negedge core_clk_in);
      addr_out = a;
      rd_out = 1'b1;
      @(posedge core_clk_in);
      d = rdata_in;
      h = hit_in;
      @(negedge core_clk_in);
      rd_out = 1'b0;
      addr_out = ~a;
   endtask : rd_byte
endmodule : ecc_core_model
`default_nettype wire

// ===== dv/test_excitation_current_control.sv
// Bench for the excitation current control register.
// Assumes the core model drives the SFR bus; checks readback and ctrl_out.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module test_excitation_current_control;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic clk_en_in = 1'b1;
   logic [7:0] addr, wdata, rdata, d;
   logic wr, rd, hit, h;
   ecc_pkg::ecc_ctrl_t ctrl;
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [7:0] vals [7] = '{8'h8f, 8'h70, 8'h0b, 8'h07, 8'h40, 8'h20, 8'h10};
   always #20 core_clk_in = ~core_clk_in;
   ecc_core_model u_ecc_core_model(.core_clk_in(core_clk_in), .rdata_in(rdata), .hit_in(hit),
      .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
   ecc_regs u_ecc_regs(.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
      .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd),
      .sfr_rdata_out(rdata), .sfr_hit_out(hit), .ctrl_out(ctrl));
   ////////////////////////////////////////////////////////////////////////////
   // Pin masks: bit1 source two present, bit0 source one present
   function automatic ecc_pkg::ecc_ctrl_t exp_ctrl(input logic [7:0] b);
      return {b[6], b[5], b[4], b[1] & b[3], b[0] & ~b[2], b[1] & ~b[3], b[0] & b[2]};
   endfunction : exp_ctrl
   // Readback drops the reserved bit; outputs follow the stored byte
   task automatic check_reg(input logic [7:0] e);
      u_ecc_core_model.rd_byte(8'hd5, d, h);
      `CHK("readback", e & 8'h7f, d)
      `CHK("hit", 1'b1, h)
      `CHK("ctrl", exp_ctrl(e), ctrl)
   endtask : check_reg
   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////
   // Hang guard, far above the few dozen cycles the sequence needs
   always @(posedge core_clk_in)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         fails++;
         report_and_stop();
      end
   end
   // Main sequence
   initial
   begin
      repeat (6) @(negedge core_clk_in);
      rst_in = 1'b0;
      check_reg(8'h00);
      foreach (vals[i])
      begin
         u_ecc_core_model.wr_byte(8'hd5, vals[i]);
         check_reg(vals[i]);
      end
      u_ecc_core_model.wr_byte(8'hd4, 8'h5a);
      check_reg(8'h10);
      u_ecc_core_model.rd_byte(8'hd4, d, h);
      `CHK("other_addr", 8'h00, d)
      `CHK("other_hit", 1'b0, h)
      clk_en_in = 1'b0;
      u_ecc_core_model.wr_byte(8'hd5, 8'h0f);
      clk_en_in = 1'b1;
      check_reg(8'h10);
      rst_in = 1'b1;
      @(negedge core_clk_in);
      rst_in = 1'b0;
      check_reg(8'h00);
      report_and_stop();
   end
endmodule : test_excitation_current_control
`default_nettype wire
